// File: logic/eia_pkg.sv
/*
 * Shared constants for the input function assignment block: register map,
 * function codes, polarity codes, reset values and timing.
 * Assumes a 200 MHz core clock and a 12-bit AXI4-Lite byte address.
 */
package eia_pkg;
   // =========================================================================
   // Sizes
   localparam int NUM_IN = 8;
   localparam int ADDR_W = 12;
   localparam int IRQ_W = 4;
   localparam int CNT_W = 18;

   // =========================================================================
   // Function and polarity codes
   localparam logic [7:0] FN_FAULT_CLEAR = 8'h12;
   localparam logic [7:0] FN_JOG = 8'h06;
   localparam logic [7:0] FN_HARD_STOP = 8'h40;
   localparam logic [7:0] FN_NONE = 8'hFF;
   localparam logic POL_NO = 1'b0;
   localparam logic POL_NC = 1'b1;

   // =========================================================================
   // Values after reset
   localparam logic [7:0] RST_FUNC_IN1 = FN_FAULT_CLEAR;
   localparam logic [7:0] RST_FUNC_IN3 = FN_JOG;
   localparam logic [7:0] RST_FUNC_OTHER = FN_NONE;
   localparam logic RST_POL = POL_NO;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

   // =========================================================================
   // Register offsets; the copy window repeats the function and polarity map.
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_FUNC_BASE = 12'h010;
   localparam logic [ADDR_W-1:0] ADDR_POL_BASE = 12'h030;
   localparam logic [ADDR_W-1:0] ADDR_COPY_OFS = 12'h100;

   // Status and interrupt bit positions.
   localparam int ST_SWITCH = 0;
   localparam int ST_TRIP = 1;
   localparam int ST_COPY_ERR = 2;
   localparam int IRQ_FORCED = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int IRQ_COPY_ERR = 2;
   localparam int IRQ_TRIP = 3;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // =========================================================================
   // Timing: the copy error indication is shown for a short while.
   localparam int CLK_PERIOD_NS = 5;
   localparam int COPY_ERR_SHOW_NS = 1000000;
   localparam int COPY_ERR_SHOW_CYC = COPY_ERR_SHOW_NS / CLK_PERIOD_NS;

   // Matches the word address of entry i of a register group.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base, input int i);
      reg_hit = (a == base + ADDR_W'(4 * i));
   endfunction
endpackage

// File: logic/eia_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; no bundle coherence is given.
 */
`timescale 1ns/1ps
module eia_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_i, // Core clock.
   input wire logic rst_n_i, // Synchronous reset, active low.
   input wire logic [W-1:0] async_i, // Levels from outside the domain.
   output logic [W-1:0] sync_o // Levels safe to use.
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;

   // =========================================================================
   // The first stage feeds only the second stage.
   always_comb begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_o <= sync_nxt;
      end
   end
endmodule

// File: logic/eia_axil_slave.sv
/*
 * AXI4-Lite slave front end. Turns bus traffic into a one-cycle write strobe
 * and a combinational read lookup into the register file next to it.
 * Assumes the register file answers rd_data_i and the ok flags in the same cycle.
 */
`timescale 1ns/1ps
module eia_axil_slave (
   input wire logic core_clk_i, // Core clock.
   input wire logic rst_n_i, // Synchronous reset, active low.
   input wire logic [eia_pkg::ADDR_W-1:0] awaddr_i, // Write address.
   input wire logic awvalid_i, // Write address valid.
   output logic awready_o, // Write address ready.
   input wire logic [31:0] wdata_i, // Write data.
   input wire logic [3:0] wstrb_i, // Write byte strobes.
   input wire logic wvalid_i, // Write data valid.
   output logic wready_o, // Write data ready.
   output logic [1:0] bresp_o, // Write response.
   output logic bvalid_o, // Write response valid.
   input wire logic bready_i, // Write response ready.
   input wire logic [eia_pkg::ADDR_W-1:0] araddr_i, // Read address.
   input wire logic arvalid_i, // Read address valid.
   output logic arready_o, // Read address ready.
   output logic [31:0] rdata_o, // Read data.
   output logic [1:0] rresp_o, // Read response.
   output logic rvalid_o, // Read data valid.
   input wire logic rready_i, // Read data ready.
   output logic wr_en_o, // One-cycle register write strobe.
   output logic [eia_pkg::ADDR_W-1:0] wr_addr_o, // Address of that write.
   output logic [31:0] wr_data_o, // Data of that write.
   output logic [3:0] wr_strb_o, // Strobes of that write.
   input wire logic wr_ok_i, // Write address is mapped.
   output logic [eia_pkg::ADDR_W-1:0] rd_addr_o, // Read lookup address.
   input wire logic [31:0] rd_data_i, // Read lookup data.
   input wire logic rd_ok_i // Read address is mapped.
);
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [eia_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_nxt, rvalid_nxt, aw_ok, w_ok;
   logic [1:0] bresp_nxt, rresp_nxt;

   // =========================================================================
   // Address and data are held apart so they may arrive in either order.
   always_comb begin
      awready_o = !aw_have_r && !bvalid_o;
      wready_o = !w_have_r && !bvalid_o;
      arready_o = !rvalid_o;
      aw_ok = aw_have_r || (awvalid_i && awready_o);
      w_ok = w_have_r || (wvalid_i && wready_o);
      wr_addr_o = aw_have_r ? awaddr_r : awaddr_i;
      wr_data_o = w_have_r ? wdata_r : wdata_i;
      wr_strb_o = w_have_r ? wstrb_r : wstrb_i;
      wr_en_o = aw_ok && w_ok && !bvalid_o;
      rd_addr_o = araddr_i;
      aw_have_nxt = aw_ok && !wr_en_o;
      w_have_nxt = w_ok && !wr_en_o;
      awaddr_nxt = wr_addr_o;
      wdata_nxt = wr_data_o;
      wstrb_nxt = wr_strb_o;
      bvalid_nxt = wr_en_o || (bvalid_o && !bready_i);
      bresp_nxt = bresp_o;
      if (wr_en_o) begin
         bresp_nxt = wr_ok_i ? eia_pkg::RESP_OKAY : eia_pkg::RESP_SLVERR;
      end
      rvalid_nxt = rvalid_o && !rready_i;
      rdata_nxt = rdata_o;
      rresp_nxt = rresp_o;
      if (arvalid_i && arready_o) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_ok_i ? rd_data_i : 32'h0000_0000;
         rresp_nxt = rd_ok_i ? eia_pkg::RESP_OKAY : eia_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_o <= 1'b0;
         bresp_o <= eia_pkg::RESP_OKAY;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
         rresp_o <= eia_pkg::RESP_OKAY;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_o <= bvalid_nxt;
         bresp_o <= bresp_nxt;
         rvalid_o <= rvalid_nxt;
         rdata_o <= rdata_nxt;
         rresp_o <= rresp_nxt;
      end
   end
endmodule

// File: logic/eia_top.sv
/*
 * Function and polarity assignment for the intelligent inputs, with the
 * hardware emergency stop enable switch, trip latch and interrupt logic.
 * Assumes the switch and the input lines are asynchronous pins, and that
 * software reaches the settings over AXI4-Lite; the copy window carries
 * settings that arrive from a settings copy rather than from the panel.
 */
// Overview of operation
// RULE1: Switch off: inputs one and three freely set; defaults fault clear, jog, open.
// RULE2: Switch on: force input one fault clear/open, three hard stop/closed, refuse changes.
// RULE3: Any input set to fault clear keeps its polarity normally open.
// RULE4: Input three set to hard stop keeps its polarity normally closed.
// RULE5: Switch turning on clears fault clear from every other input.
// RULE6: Cleared assignments stay cleared after the switch returns off.
// RULE7: Panel writes of hard stop to input three are always refused.
// RULE8: Switch turning on writes hard stop into input three by itself.
// RULE9: After switch off, input one and polarities kept, input three unassigned, writable.
// RULE10: Copy while switch on skips inputs one and three, shows copy error briefly.
// RULE11: Emergency stop enabled and input three line inactive trips the hard stop fault.
// RULE12: Only input one's line being active clears the hard stop fault, whatever its function.
// RULE13: Switch level is synchronised; forcing happens once per off-to-on edge.
`timescale 1ns/1ps
module eia_top #(
   parameter int COPY_ERR_CYC = eia_pkg::COPY_ERR_SHOW_CYC
) (
   input wire logic core_clk_i, // Core clock, 200 MHz.
   input wire logic rst_n_i, // Synchronous reset, active low.
   input wire logic [eia_pkg::ADDR_W-1:0] awaddr_i, // AXI write address.
   input wire logic awvalid_i, // AXI write address valid.
   output logic awready_o, // AXI write address ready.
   input wire logic [31:0] wdata_i, // AXI write data.
   input wire logic [3:0] wstrb_i, // AXI write strobes.
   input wire logic wvalid_i, // AXI write data valid.
   output logic wready_o, // AXI write data ready.
   output logic [1:0] bresp_o, // AXI write response.
   output logic bvalid_o, // AXI write response valid.
   input wire logic bready_i, // AXI write response ready.
   input wire logic [eia_pkg::ADDR_W-1:0] araddr_i, // AXI read address.
   input wire logic arvalid_i, // AXI read address valid.
   output logic arready_o, // AXI read address ready.
   output logic [31:0] rdata_o, // AXI read data.
   output logic [1:0] rresp_o, // AXI read response.
   output logic rvalid_o, // AXI read data valid.
   input wire logic rready_i, // AXI read data ready.
   input wire logic safety_slide_switch_i, // Emergency stop enable switch pin.
   input wire logic [eia_pkg::NUM_IN-1:0] in_pins_i, // Input terminal lines.
   output logic [eia_pkg::NUM_IN-1:0][7:0] in_func_o, // Function per input.
   output logic [eia_pkg::NUM_IN-1:0] in_pol_o, // Polarity per input.
   output logic hard_stop_fault_o, // Emergency stop trip latched.
   output logic gate_enable_o, // Output switching allowed.
   output logic copy_error_o, // Copy error indication.
   output logic irq_o // Level interrupt.
);
   localparam int I1 = 0;
   localparam int I3 = 2;

   logic wr_en, wr_ok, rd_ok, copy, sw_s, pin1_s, pin3_s;
   logic [eia_pkg::ADDR_W-1:0] wr_addr, rd_addr, wofs;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [eia_pkg::NUM_IN-1:0] pins_s;
   logic [eia_pkg::NUM_IN-1:0][7:0] func_r, func_nxt;
   logic [eia_pkg::NUM_IN-1:0] pol_r, pol_nxt;
   logic [eia_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, ev, w1c;
   logic sw_d_r, sw_d_nxt, trip_r, trip_nxt, sw_rise, sw_fall, trip_set;
   logic [eia_pkg::CNT_W-1:0] cnt_r, cnt_nxt;

   // =========================================================================
   // Bus front end.
   eia_axil_slave u_bus (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
      .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
      .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
      .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
      .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
      .rvalid_o(rvalid_o), .rready_i(rready_i), .wr_en_o(wr_en),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_strb_o(wr_strb),
      .wr_ok_i(wr_ok), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_ok_i(rd_ok)
   );

   // =========================================================================
   // Pin synchronisers; the switch shares them with the input lines.
   eia_sync #(.W(eia_pkg::NUM_IN + 1)) u_sync (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .async_i({safety_slide_switch_i, in_pins_i}),
      .sync_o({sw_s, pins_s})
   );

   // Edges come from the synchronised level against its own last sample.
   always_comb begin
      pin1_s = pins_s[I1];
      pin3_s = pins_s[I3];
      sw_d_nxt = sw_s;
      sw_rise = sw_s && !sw_d_r; // see RULE13
      sw_fall = !sw_s && sw_d_r;
   end

   // =========================================================================
   // Settings, interrupt and trip next state.
   always_comb begin
      func_nxt = func_r;
      pol_nxt = pol_r;
      irq_mask_nxt = irq_mask_r;
      ev = '0;
      w1c = '0;
      wr_ok = 1'b0;
      copy = (wr_addr & eia_pkg::ADDR_COPY_OFS) != '0;
      wofs = wr_addr & ~eia_pkg::ADDR_COPY_OFS;
      if (wr_en) begin
         if (!copy && wr_addr == eia_pkg::ADDR_IRQ_MASK) begin
            wr_ok = 1'b1;
            if (wr_strb[0]) begin
               irq_mask_nxt = wr_data[eia_pkg::IRQ_W-1:0];
            end
         end
         if (!copy && wr_addr == eia_pkg::ADDR_IRQ_STAT) begin
            wr_ok = 1'b1;
            if (wr_strb[0]) begin
               w1c = wr_data[eia_pkg::IRQ_W-1:0];
            end
         end
         for (int i = 0; i < eia_pkg::NUM_IN; i++) begin
            if (eia_pkg::reg_hit(wofs, eia_pkg::ADDR_FUNC_BASE, i) ||
                eia_pkg::reg_hit(wofs, eia_pkg::ADDR_POL_BASE, i)) begin
               wr_ok = 1'b1;
               if (sw_d_r && (i == I1 || i == I3)) begin
                  // Locked while the emergency stop is enabled.
                  ev[eia_pkg::IRQ_COPY_ERR] = copy; // see RULE10
                  ev[eia_pkg::IRQ_REFUSED] = !copy; // see RULE2
               end else if (eia_pkg::reg_hit(wofs, eia_pkg::ADDR_FUNC_BASE, i)) begin
                  if (!copy && i == I3 && wr_data[7:0] == eia_pkg::FN_HARD_STOP) begin
                     ev[eia_pkg::IRQ_REFUSED] = 1'b1; // see RULE7
                  end else if (wr_strb[0]) begin
                     func_nxt[i] = wr_data[7:0]; // see RULE1
                  end
               end else if (wr_strb[0]) begin
                  pol_nxt[i] = wr_data[0]; // see RULE1
               end
            end
         end
      end
      // Forcing is applied after the bus so an edge wins over a same-cycle write.
      if (sw_rise) begin
         for (int i = 0; i < eia_pkg::NUM_IN; i++) begin
            if (i != I1 && i != I3 && func_nxt[i] == eia_pkg::FN_FAULT_CLEAR) begin
               func_nxt[i] = eia_pkg::FN_NONE; // see RULE5
            end
         end
         func_nxt[I1] = eia_pkg::FN_FAULT_CLEAR; // see RULE2
         pol_nxt[I1] = eia_pkg::POL_NO;
         func_nxt[I3] = eia_pkg::FN_HARD_STOP; // see RULE8
         pol_nxt[I3] = eia_pkg::POL_NC;
         ev[eia_pkg::IRQ_FORCED] = 1'b1;
      end
      // Only input three's function is released; nothing cleared comes back.
      if (sw_fall) begin // see RULE6
         func_nxt[I3] = eia_pkg::FN_NONE; // see RULE9
      end
      for (int i = 0; i < eia_pkg::NUM_IN; i++) begin
         if (func_nxt[i] == eia_pkg::FN_FAULT_CLEAR) begin
            pol_nxt[i] = eia_pkg::POL_NO; // see RULE3
         end
      end
      if (func_nxt[I3] == eia_pkg::FN_HARD_STOP) begin
         pol_nxt[I3] = eia_pkg::POL_NC; // see RULE4
      end
      // A de-energised line three trips; an open wire reads low as well.
      trip_set = sw_s && !pin3_s; // see RULE11
      // Clearing needs input one's line active; its function is not checked and the bus has no path here.
      trip_nxt = trip_set || (trip_r && !(pin1_s ^ pol_r[I1])); // see RULE12
      ev[eia_pkg::IRQ_TRIP] = trip_set && !trip_r;
      // A set in the same cycle as its clear is kept.
      irq_stat_nxt = (irq_stat_r & ~w1c) | ev;
      cnt_nxt = cnt_r;
      if (ev[eia_pkg::IRQ_COPY_ERR]) begin
         cnt_nxt = eia_pkg::CNT_W'(COPY_ERR_CYC); // see RULE10
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // =========================================================================
   // Settings registers.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < eia_pkg::NUM_IN; i++) begin
            func_r[i] <= eia_pkg::RST_FUNC_OTHER;
            pol_r[i] <= eia_pkg::RST_POL;
         end
         func_r[I1] <= eia_pkg::RST_FUNC_IN1; // see RULE1
         func_r[I3] <= eia_pkg::RST_FUNC_IN3;
         irq_stat_r <= '0;
         irq_mask_r <= eia_pkg::RST_IRQ_MASK;
         sw_d_r <= 1'b0;
         trip_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         func_r <= func_nxt;
         pol_r <= pol_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         sw_d_r <= sw_d_nxt;
         trip_r <= trip_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // =========================================================================
   // Read lookup and outputs.
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      if (rd_addr == eia_pkg::ADDR_STATUS) begin
         rd_data[eia_pkg::ST_SWITCH] = sw_d_r;
         rd_data[eia_pkg::ST_TRIP] = trip_r;
         rd_data[eia_pkg::ST_COPY_ERR] = cnt_r != '0;
      end else if (rd_addr == eia_pkg::ADDR_IRQ_STAT) begin
         rd_data[eia_pkg::IRQ_W-1:0] = irq_stat_r;
      end else if (rd_addr == eia_pkg::ADDR_IRQ_MASK) begin
         rd_data[eia_pkg::IRQ_W-1:0] = irq_mask_r;
      end else begin
         rd_ok = 1'b0;
         for (int i = 0; i < eia_pkg::NUM_IN; i++) begin
            if (eia_pkg::reg_hit(rd_addr, eia_pkg::ADDR_FUNC_BASE, i)) begin
               rd_ok = 1'b1;
               rd_data[7:0] = func_r[i];
            end
            if (eia_pkg::reg_hit(rd_addr, eia_pkg::ADDR_POL_BASE, i)) begin
               rd_ok = 1'b1;
               rd_data[0] = pol_r[i];
            end
         end
      end
      in_func_o = func_r;
      in_pol_o = pol_r;
      hard_stop_fault_o = trip_r;
      gate_enable_o = !trip_r; // see RULE11
      copy_error_o = cnt_r != '0;
      irq_o = |(irq_stat_r & irq_mask_r);
   end

   // =========================================================================
   // Checks.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic pol_bad, other_rs, panel_emr, copy_locked, free_wr1;
   always_comb begin
      pol_bad = 1'b0;
      other_rs = 1'b0;
      for (int i = 0; i < eia_pkg::NUM_IN; i++) begin
         pol_bad |= func_r[i] == eia_pkg::FN_FAULT_CLEAR && pol_r[i] != eia_pkg::POL_NO;
         other_rs |= i != I1 && i != I3 && func_r[i] == eia_pkg::FN_FAULT_CLEAR;
      end
      panel_emr = wr_en && !copy && eia_pkg::reg_hit(wofs, eia_pkg::ADDR_FUNC_BASE, I3) &&
                  wr_data[7:0] == eia_pkg::FN_HARD_STOP && !sw_rise && !sw_fall;
      copy_locked = wr_en && copy && sw_d_r &&
                    (eia_pkg::reg_hit(wofs, eia_pkg::ADDR_FUNC_BASE, I1) ||
                     eia_pkg::reg_hit(wofs, eia_pkg::ADDR_POL_BASE, I3));
      // A free write to input one, from the panel or a copy, while the switch is off.
      free_wr1 = wr_en && !sw_d_r && !sw_rise && wr_strb[0] &&
                 eia_pkg::reg_hit(wofs, eia_pkg::ADDR_FUNC_BASE, I1);
   end

   sequence s_forced;
      func_r[I1] == eia_pkg::FN_FAULT_CLEAR && func_r[I3] == eia_pkg::FN_HARD_STOP &&
      pol_r[I1] == eia_pkg::POL_NO && pol_r[I3] == eia_pkg::POL_NC;
   endsequence
   sequence s_copy_shown;
      copy_error_o [*3];
   endsequence

   AST_LOCKED_WHILE_ON: assert property (sw_d_r |-> s_forced) // see RULE2
      else $error("Locked inputs lost their forced settings.");
   AST_RS_POL_OPEN: assert property (!pol_bad) // see RULE3
      else $error("Fault clear input not normally open.");
   AST_EMR_POL_CLOSED: assert property (
      func_r[I3] == eia_pkg::FN_HARD_STOP |-> pol_r[I3] == eia_pkg::POL_NC) // see RULE4
      else $error("Hard stop input not normally closed.");
   AST_RISE_FORCES: assert property (sw_rise |=> s_forced ##0 !other_rs) // see RULE5
      else $error("Switch on did not force assignments.");
   AST_FALL_RELEASES: assert property (sw_fall && !wr_en |=>
      func_r[I3] == eia_pkg::FN_NONE && pol_r[I3] == eia_pkg::POL_NC &&
      func_r[I1] == eia_pkg::FN_FAULT_CLEAR) // see RULE9
      else $error("Switch off did not release input three.");
   AST_PANEL_EMR_REFUSED: assert property (panel_emr |=>
      irq_stat_r[eia_pkg::IRQ_REFUSED] && $stable(func_r[I3])) // see RULE7
      else $error("Panel hard stop write was taken.");
   // Only the locked fields must hold; other inputs of the same copy may land meanwhile.
   AST_COPY_ERROR: assert property (copy_locked |=> // see RULE10
      ($stable(func_r[I1]) && $stable(pol_r[I3])) ##0 s_copy_shown)
      else $error("Locked copy not skipped or not shown.");
   AST_TRIP: assert property (sw_s && !pin3_s |=> hard_stop_fault_o && !gate_enable_o) // see RULE11
      else $error("Inactive line three did not trip.");
   AST_TRIP_HOLD: assert property (trip_r && !(pin1_s ^ pol_r[I1]) |=> trip_r) // see RULE12
      else $error("Trip cleared without fault clear.");
   AST_ONE_EDGE: assert property (sw_rise |=> !sw_rise) // see RULE13
      else $error("Switch edge seen twice.");
   // Switching off touches input three only; a cleared input must not come back.
   AST_FALL_NO_RESTORE: assert property (sw_fall && !wr_en |=> // see RULE6
      $stable(func_r[1]) && $stable(func_r[eia_pkg::NUM_IN-1:3]))
      else $error("Switch off changed another input function.");
   AST_FREE_WRITE: assert property (free_wr1 |=> func_r[I1] == $past(wr_data[7:0])) // see RULE1
      else $error("Free write to input one was not stored.");
endmodule

// File: test/test_eia_top.sv
/*
 * Self-checking bench for the input function assignment block over AXI4-Lite.
 * Assumes eia_pkg is compiled first and the copy error time is cut to 8 cycles.
 */
`timescale 1ns/1ps
module test_eia_top;
   // ======================================================================
   // Stimulus and observed signals
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] awaddr_i = 12'h000;
   logic [11:0] araddr_i = 12'h000;
   logic [31:0] wdata_i = 32'h0;
   logic [3:0] wstrb_i = 4'h1;
   logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b1;
   logic arvalid_i = 1'b0, rready_i = 1'b1, safety_slide_switch_i = 1'b0;
   logic [7:0] in_pins_i = 8'h04;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
   logic hard_stop_fault_o, gate_enable_o, copy_error_o;
   logic [1:0] bresp_o, rresp_o, rd_r, wr_r;
   logic [31:0] rdata_o, rd_d;
   logic [7:0][7:0] in_func_o;
   logic [7:0] in_pol_o;
   int bad_count = 0;
   int num_checks = 0;
   eia_top #(.COPY_ERR_CYC(8)) dut_u (.core_clk_i, .rst_n_i, .awaddr_i, .awvalid_i,
      .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
      .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
      .rready_i, .safety_slide_switch_i, .in_pins_i, .in_func_o, .in_pol_o,
      .hard_stop_fault_o, .gate_enable_o, .copy_error_o, .irq_o);
   // A 5 ns period gives the 200 MHz core clock.
   always #2.5 core_clk_i = ~core_clk_i;
   // ======================================================================
   // Closing report and comparison
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Handshakes are sampled at the rising edge; bready and rready stay high all along.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      awaddr_i <= a;
      wdata_i <= d;
      {awvalid_i, wvalid_i} <= 2'b11;
      while (!done && n < 50) begin
         @(posedge core_clk_i);
         if (awvalid_i && awready_o) awvalid_i <= 1'b0;
         if (wvalid_i && wready_o) wvalid_i <= 1'b0;
         {done, wr_r} = {bvalid_o, bresp_o};
         n++;
      end
      if (!done) begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      araddr_i <= a;
      arvalid_i <= 1'b1;
      while (!done && n < 50) begin
         @(posedge core_clk_i);
         if (arvalid_i && arready_o) arvalid_i <= 1'b0;
         {done, rd_d, rd_r} = {rvalid_o, rdata_o, rresp_o};
         n++;
      end
      if (!done) begin
         bad_count++;
         test_done();
      end
   endtask
   // ======================================================================
   // Main sequence; fixed waits cover the synchroniser and edge detector delay.
   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      chk(in_func_o[0], 32'h12);
      chk(in_func_o[2], 32'h06);
      wr(12'h008, 32'h2);
      wr(12'h014, 32'h12);
      wr(12'h034, 32'h1);
      chk(in_pol_o[1], 32'h0);
      wr(12'h018, 32'h40);
      chk(in_func_o[2], 32'h06);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 32'h1);
      wr(12'h004, 32'h2);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 32'h0);
      $display("test free settings done");
      safety_slide_switch_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      chk({in_func_o[0], in_func_o[2], 7'h0, in_pol_o[0]}, 32'h124000);
      chk({in_func_o[1], 7'h0, in_pol_o[2]}, 32'hFF01);
      wr(12'h010, 32'h06);
      chk(in_func_o[0], 32'h12);
      chk(wr_r, 32'h0);
      wr(12'h110, 32'h06);
      wr(12'h11C, 32'h06);
      chk({copy_error_o, in_func_o[0], in_func_o[3]}, 32'h11206);
      repeat (12) @(posedge core_clk_i);
      chk(copy_error_o, 32'h0);
      in_pins_i <= 8'h00;
      repeat (4) @(posedge core_clk_i);
      wr(12'h004, 32'hF);
      chk({hard_stop_fault_o, gate_enable_o}, 32'h2);
      in_pins_i <= 8'h05;
      repeat (4) @(posedge core_clk_i);
      chk({hard_stop_fault_o, gate_enable_o}, 32'h1);
      $display("test switch on done");
      wr(12'h01C, 32'h12);
      safety_slide_switch_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      chk({in_func_o[0], in_func_o[2], in_func_o[1], 7'h0, in_pol_o[2]}, 32'h12FFFF01);
      wr(12'h010, 32'h06);
      rd(12'h010);
      chk(rd_d, 32'h06);
      rd(12'h0FC);
      chk(rd_r, 32'h2);
      $display("test switch off done");
      test_done();
   end
endmodule
